/* File: hw/adc_convert_read_port.sv */
/*
  converter control and readout port: start strobe handling, power-up pulse,
  busy flag, auto power-down, two-read result bus.
  assumes all pins synchronous to clk; the analog core result arrives on
  sample_data and is captured at conversion end.
*/
// What this block does
// - rising start pin makes an internal high-going power-up pulse lasting 1.5 us
// - falling start pin converts now if pulse done, else when pulse ends
// - start pin level at conversion end chooses power-down or stay powered
// - bus driven only while chip select and read both low
// - chip select alone never enables the outputs
// - result bus is eight bits, floating when not read
// - busy is high for the whole conversion, low when done
// - power-saving mode powers down after each conversion, up before next
// - result read MSB part first then LSB part, 10 ns apart
`timescale 1ns/1ps
`include "adc_convert_read_port_defs.svh"

module adc_convert_read_port #(
  parameter int RESULT_W   = `RESULT_WIDTH,
  parameter int PWR_CYCLES = `POWER_UP_CYCLES,
  parameter int CNV_CYCLES = `CONVERT_CYCLES
) (
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                conversion_start_n,
  input  wire logic                chip_select_n,
  input  wire logic                read_n,
  input  wire logic [RESULT_W-1:0] sample_data,
  output logic                     busy,
  output logic                     powered,
  output logic [7:0]               result_bus_o,
  output logic [7:0]               result_bus_oe
);

  localparam int CW = 12;

  adc_convert_read_port_pkg::conv_state_t state_reg, state_next;
  logic [CW-1:0]       pwr_cnt_reg, pwr_cnt_next;
  logic [CW-1:0]       cnv_cnt_reg, cnv_cnt_next;
  logic                start_d_reg, start_d_next;
  logic                pulse_reg, pulse_next;     // high while power-up pulse active
  logic                pending_reg, pending_next; // fall seen during pulse
  logic [RESULT_W-1:0] result_reg, result_next;
  logic                lsb_sel_reg, lsb_sel_next;
  logic                rd_d_reg, rd_d_next;
  logic                busy_reg, busy_next;
  logic                pow_reg, pow_next;
  logic [7:0]          dout_reg, dout_next;
  logic [7:0]          oe_reg, oe_next;
  logic                start_rise, start_fall, read_act;

  // pin edge detect; start_d resets low, so the pin must be low at release
  assign start_rise = conversion_start_n & ~start_d_reg;
  assign start_fall = ~conversion_start_n & start_d_reg;
  assign read_act   = ~chip_select_n & ~read_n;

  // conversion sequencing
  always_comb begin
    state_next   = state_reg;
    pwr_cnt_next = pwr_cnt_reg;
    cnv_cnt_next = cnv_cnt_reg;
    pulse_next   = pulse_reg;
    pending_next = pending_reg;
    result_next  = result_reg;
    busy_next    = busy_reg;
    pow_next     = pow_reg;
    start_d_next = conversion_start_n;
    if (start_rise && state_reg != adc_convert_read_port_pkg::ST_CONVERT) begin
      pulse_next   = 1'b1;
      pwr_cnt_next = CW'(PWR_CYCLES - 1);
      pow_next     = 1'b1;
      pending_next = 1'b0;
    end else if (pulse_reg) begin
      if (start_fall)
        pending_next = 1'b1;
      if (pwr_cnt_reg == '0)
        pulse_next = 1'b0;
      else
        pwr_cnt_next = pwr_cnt_reg - 1'b1;
    end
    case (state_reg)
      adc_convert_read_port_pkg::ST_DOWN,
      adc_convert_read_port_pkg::ST_IDLE: begin
        // start on gated fall: pin fall after pulse, or pulse end with pin low
        if ((pow_reg && !pulse_reg && start_fall) ||
            (pulse_reg && pwr_cnt_reg == '0 && (pending_reg || start_fall))) begin
          state_next   = adc_convert_read_port_pkg::ST_CONVERT;
          cnv_cnt_next = CW'(CNV_CYCLES - 1);
          busy_next    = 1'b1;
          pending_next = 1'b0;
        end
      end
      adc_convert_read_port_pkg::ST_CONVERT: begin
        if (cnv_cnt_reg == '0) begin
          busy_next   = 1'b0;
          result_next = sample_data;
          // low pin at end: power down; high pin: stay up
          if (conversion_start_n) begin
            state_next = adc_convert_read_port_pkg::ST_IDLE;
          end else begin
            state_next = adc_convert_read_port_pkg::ST_DOWN;
            pow_next   = 1'b0;
          end
        end else begin
          cnv_cnt_next = cnv_cnt_reg - 1'b1;
        end
      end
      default: state_next = adc_convert_read_port_pkg::ST_DOWN;
    endcase
  end

  // sequencing registers; reset parks the converter powered down
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg   <= adc_convert_read_port_pkg::ST_DOWN;
      pwr_cnt_reg <= '0;
      cnv_cnt_reg <= '0;
      start_d_reg <= 1'b0;
      pulse_reg   <= 1'b0;
      pending_reg <= 1'b0;
      result_reg  <= '0;
      busy_reg    <= 1'b0;
      pow_reg     <= 1'b0;
    end else begin
      state_reg   <= state_next;
      pwr_cnt_reg <= pwr_cnt_next;
      cnv_cnt_reg <= cnv_cnt_next;
      start_d_reg <= start_d_next;
      pulse_reg   <= pulse_next;
      pending_reg <= pending_next;
      result_reg  <= result_next;
      busy_reg    <= busy_next;
      pow_reg     <= pow_next;
    end
  end

  // read port: msb part first, lsb part on the following read
  always_comb begin
    rd_d_next    = read_act;
    lsb_sel_next = lsb_sel_reg;
    dout_next    = dout_reg;
    oe_next      = 8'h00;                       // float unless read
    if (busy_next && !busy_reg)
      lsb_sel_next = 1'b0;                      // conversion start (busy rise) restarts the pair
    else if (rd_d_reg && !read_act)
      lsb_sel_next = ~lsb_sel_reg;
    if (read_act) begin
      oe_next   = 8'hff;                        // needs both strobes
      dout_next = lsb_sel_reg ?
                  {6'h00, result_reg[1:0]} :
                  result_reg[RESULT_W-1 -: 8];
    end
  end

  // read port registers; data lags the strobes by one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_d_reg    <= 1'b0;
      lsb_sel_reg <= 1'b0;
      dout_reg    <= 8'h00;
      oe_reg      <= 8'h00;
    end else begin
      rd_d_reg    <= rd_d_next;
      lsb_sel_reg <= lsb_sel_next;
      dout_reg    <= dout_next;
      oe_reg      <= oe_next;
    end
  end

  // every output comes straight from a flip-flop
  assign busy          = busy_reg;
  assign powered       = pow_reg;
  assign result_bus_o  = dout_reg;
  assign result_bus_oe = oe_reg;

  sequence s_pulse_start;
    !srst && start_rise && state_reg != adc_convert_read_port_pkg::ST_CONVERT;
  endsequence

  chk_pulse_length: assert property (@(posedge clk) disable iff (srst)
    s_pulse_start |=> pulse_reg [*8])
    else $error("power-up pulse ended early");

  chk_oe_needs_read: assert property (@(posedge clk) disable iff (srst)
    (!chip_select_n && read_n) |=> oe_reg == 8'h00)
    else $error("outputs enabled by chip select alone");

  chk_oe_on_read: assert property (@(posedge clk) disable iff (srst)
    read_act |=> oe_reg == 8'hff)
    else $error("outputs not enabled during read");

  chk_busy_start: assert property (@(posedge clk) disable iff (srst)
    $rose(busy_reg) |-> state_reg == adc_convert_read_port_pkg::ST_CONVERT)
    else $error("busy rose without conversion");

  chk_busy_hold: assert property (@(posedge clk) disable iff (srst)
    $rose(busy_reg) |-> busy_reg [*8])
    else $error("busy dropped during conversion");

  chk_no_start_in_pulse: assert property (@(posedge clk) disable iff (srst)
    (pulse_reg && pwr_cnt_reg != '0) |=> !$rose(busy_reg))
    else $error("conversion began before power-up pulse ended");

  chk_down_on_low: assert property (@(posedge clk) disable iff (srst)
    (busy_reg && !busy_next && !conversion_start_n) |=> !pow_reg)
    else $error("no power-down with start pin low");

  chk_result_stable: assert property (@(posedge clk) disable iff (srst)
    (!busy_reg && !busy_next) |=> $stable(result_reg))
    else $error("result changed outside conversion end");

  // last conversion cycle with the start pin still high
  sequence s_conv_end_high;
    busy_reg && !busy_next && conversion_start_n;
  endsequence

  chk_stay_powered: assert property (@(posedge clk) disable iff (srst)
    s_conv_end_high |=> pow_reg && !busy_reg)
    else $error("power lost with start pin high");

  chk_conv_powered: assert property (@(posedge clk) disable iff (srst)
    busy_reg |-> pow_reg)
    else $error("converting while powered down");

  chk_float_idle: assert property (@(posedge clk) disable iff (srst)
    !read_act |=> oe_reg == 8'h00)
    else $error("bus driven without a read");

endmodule : adc_convert_read_port

/* File: hw/adc_convert_read_port_defs.svh */
/*
  timing counts and field positions for the converter control and readout port.
  assumes a 100 MHz clock (10 ns period).
*/
`ifndef ADC_CONVERT_READ_PORT_DEFS_SVH
`define ADC_CONVERT_READ_PORT_DEFS_SVH

`define CLK_PERIOD_NS      10
`define POWER_UP_NS        1500
`define POWER_UP_CYCLES    ((`POWER_UP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONVERT_NS         2300
`define CONVERT_CYCLES     (`CONVERT_NS / `CLK_PERIOD_NS)
`define READ_GAP_NS        10
`define READ_GAP_CYCLES    ((`READ_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESULT_WIDTH       10
`define LSB_FIELD_POS      6

`endif

/* File: hw/adc_convert_read_port_pkg.sv */
/*
  types for the converter control and readout port.
  assumes nothing beyond the defs header.
*/
package adc_convert_read_port_pkg;
  typedef enum logic [1:0] {
    ST_DOWN,
    ST_IDLE,
    ST_CONVERT
  } conv_state_t;
endpackage : adc_convert_read_port_pkg

/* File: verif/host_model.sv */
/* host model: drives the start pin and the read strobes, reads the bus.
   assumes the converter port shares clk and drives oe all ones or none. */
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  input  wire logic [7:0] bus_o,
  input  wire logic [7:0] bus_oe,
  output logic            start_n,
  output logic            cs_n,
  output logic            rd_n
);
  logic [7:0] last = 8'h00;
  logic [7:0] bus;
  initial begin
    start_n = 1'b0;
    cs_n = 1'b1;
    rd_n = 1'b1;
  end
  // released bus shows the inverse, so a stale value cannot pass
  assign bus = (bus_oe === 8'hff) ? bus_o : ~last;
  always @(posedge clk) begin
    if (bus_oe === 8'hff) last <= bus_o;
  end
  // start pin level change at the edge
  task pin(input logic v);
    @(posedge clk) start_n <= v;
  endtask : pin
  // wait out track and hold settling before a new start
  task settle();
    repeat (10) @(posedge clk);
  endtask : settle
  // strobes held until data is taken, then an idle gap
  task rd(input logic c, input logic r, output logic [7:0] d, output logic [7:0] e);
    @(posedge clk) cs_n <= c;
    rd_n <= r;
    repeat (2) @(posedge clk);
    #1 d = bus;
    e = bus_oe;
    @(posedge clk) cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
  endtask : rd
endmodule : host_model

/* File: verif/tb_top.sv */
/* self-checking bench for the converter port.
   assumes short counts of 8 cycles and the host model beside it. */
`timescale 1ns/1ps
module tb_top;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic [9:0] sample_data = 10'h2a5;
  logic       busy, powered, start_n, cs_n, rd_n;
  logic [7:0] bus_o, bus_oe;
  int         fails = 0;
  int         checked = 0;
  always #5 clk = ~clk;
  adc_convert_read_port #(.PWR_CYCLES(8), .CNV_CYCLES(8)) dut (
    .clk(clk), .srst(srst), .conversion_start_n(start_n),
    .chip_select_n(cs_n), .read_n(rd_n), .sample_data(sample_data),
    .busy(busy), .powered(powered), .result_bus_o(bus_o), .result_bus_oe(bus_oe));
  host_model host (.clk(clk), .bus_o(bus_o), .bus_oe(bus_oe),
    .start_n(start_n), .cs_n(cs_n), .rd_n(rd_n));
  task chk(input string n, input logic [9:0] s, input logic [9:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // bounded wait on busy; a busy fall marks the end of conversion
  task wait_busy(input logic v, output int n);
    n = 0;
    while (busy !== v) begin
      @(posedge clk) #1 n++;
      if (n > 40) begin
        $display("ERROR wait_busy expected %0b seen %0b", v, busy);
        fails++;
        wrap_up();
      end
    end
  endtask : wait_busy
  // power-up pulse, early fall, power-down, then the two reads
  task t_single();
    logic [7:0] d, e;
    int n;
    host.pin(1'b1);
    repeat (2) @(posedge clk);
    #1 chk("powered", powered, 1'b1);
    host.pin(1'b0);
    wait_busy(1'b1, n);
    // rise seen two edges before the fall request; pulse of 8 leaves 6 to wait
    chk("pulse_wait", 10'(n), 10'd6);
    wait_busy(1'b0, n);
    chk("busy_len", 10'(n), 10'd8);
    @(posedge clk) sample_data <= 10'h0ff;
    #1 chk("powered", powered, 1'b0);
    host.rd(1'b0, 1'b1, d, e);
    chk("cs_only_oe", e, 8'h00);
    host.rd(1'b1, 1'b0, d, e);
    chk("rd_only_oe", e, 8'h00);
    host.rd(1'b0, 1'b0, d, e);
    chk("read_oe", e, 8'hff);
    chk("msb", d, 8'ha9);
    host.rd(1'b0, 1'b0, d, e);
    chk("lsb", d, 8'h01);
    #1 chk("float_oe", bus_oe, 8'h00);
    $display("t_single done");
  endtask : t_single
  // pin high at conversion end keeps power; next fall starts at once
  task t_fast();
    logic [7:0] d, e;
    int n;
    host.pin(1'b1);
    repeat (12) @(posedge clk);
    host.pin(1'b0);
    wait_busy(1'b1, n);
    chk("direct", n <= 3, 1'b1);
    host.pin(1'b1);
    wait_busy(1'b0, n);
    @(posedge clk) #1 chk("stay_up", powered, 1'b1);
    // one msb read leaves the pointer on lsb; the next busy rise must reset it
    host.rd(1'b0, 1'b0, d, e);
    chk("msb_again", d, 8'h3f);
    host.settle();
    sample_data <= 10'h156;
    host.pin(1'b0);
    wait_busy(1'b1, n);
    chk("idle_start", n <= 3, 1'b1);
    wait_busy(1'b0, n);
    @(posedge clk) #1 chk("down", powered, 1'b0);
    host.rd(1'b0, 1'b0, d, e);
    chk("msb_new", d, 8'h55);
    $display("t_fast done");
  endtask : t_fast
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_single();
    host.settle();
    t_fast();
    wrap_up();
  end
endmodule : tb_top
